// ### inc/vram_ctrl_pkg.sv
package vram_ctrl_pkg;
    // core clock and its period in picoseconds
    localparam int unsigned CLK_HZ           = 40_000_000;
    localparam int unsigned CLK_PERIOD_PS    = 25_000;
    // power-up pause, least time, rounded down
    localparam int unsigned PAUSE_US         = 200;
    localparam int unsigned PAUSE_CYC        = (PAUSE_US * (CLK_HZ / 1_000_000));
    // refresh period, longest time, spread over all rows (rounded down)
    localparam int unsigned REF_PERIOD_MS    = 8;
    localparam int unsigned REF_ROWS         = 512;
    localparam int unsigned REF_PERIOD_CYC   = REF_PERIOD_MS * (CLK_HZ / 1_000);
    localparam int unsigned REF_INTERVAL_CYC = REF_PERIOD_CYC / REF_ROWS;
    localparam int unsigned INIT_CYCLES      = 8;
    // strobe phase lengths in core cycles of 25 ns (PRE_CYC 2 x 25 ns = 50 ns, RAS_CYC 4 x 25 ns = 100 ns)
    localparam int unsigned PRE_CYC          = 2;
    localparam int unsigned RAS_CYC          = 4;
    localparam int unsigned RCD_CYC          = 1;
    localparam int unsigned CSR_CYC          = 1;
    localparam int unsigned ROW_W            = 9;
    localparam int unsigned ADDR_W           = 9;
    localparam int unsigned DATA_W           = 8;
    localparam logic [ROW_W-1:0] ROW_RESET   = 9'h000;

    typedef struct packed {
        logic             rasN;
        logic             casN;
        logic             weN;
        logic             dtOeN;
        logic             scClk;
        logic [ADDR_W-1:0] addr;
    } ram_pins_t;

    typedef struct packed {
        logic             write;
        logic [ROW_W-1:0] row;
        logic [ADDR_W-1:0] col;
        logic [DATA_W-1:0] wdata;
    } access_req_t;
endpackage

// ### logic/vram_pace_timer.sv
`timescale 1ns/1ps
`default_nettype none
module vram_pace_timer
    import vram_ctrl_pkg::*;
#(
    parameter int unsigned LOAD = 16
) (
    input  wire logic core_clk, // core clock
    input  wire logic rst,      // synchronous reset
    input  wire logic restart,  // reload the count
    output logic      tick      // one-cycle pulse every LOAD cycles
);
    logic [23:0] count_r;
    logic [23:0] count_nxt;
    logic        tick_nxt;

    always_comb begin
        tick_nxt  = 1'b0;
        count_nxt = count_r - 24'h00_0001;
        if (restart) begin
            count_nxt = 24'(LOAD - 1);
        end else if (count_r == 24'h00_0000) begin
            count_nxt = 24'(LOAD - 1);
            tick_nxt  = 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            count_r <= 24'(LOAD - 1);
            tick    <= 1'b0;
        end else begin
            count_r <= count_nxt;
            tick    <= tick_nxt;
        end
    end
endmodule // vram_pace_timer
`default_nettype wire

// ### logic/vram_host_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// (R1) wait at least 200 us after power-up before any cycle
// (R2) then eight row-strobe cycles and eight shift clocks, transfer/output-enable high
// (R3) with internal row counter, use eight column-before-row cycles instead
// (R4) refresh all 512 rows within every 8 ms
// (R5) write enable low before column strobe falls gives early write, outputs off
// (R6) late write enable after strobes gives read-write with data driven first
// (R7) other write timing leaves device outputs undefined; never rely on them
// (R8) write data taken at column strobe (early) or write enable (read-write)
// (R9) a read holds write enable high past column or row strobe rise
// (R10) late column strobe means data only after column-strobe access time
// (R11) late column address means data only after column-address access time
// (R12) hold row strobe and transfer/output-enable high during power-up
// (R13) after power-up data pins and flag are off, serial port input
// (R14) each cycle starts with row strobe falling, column strobe high; ends both high (column-before-row cycles here drop column strobe first)
// (R15) spread refreshes evenly and arbitrate them against pending accesses
module vram_host_ctrl
    import vram_ctrl_pkg::*;
#(
    parameter int unsigned PAUSE_LEN = PAUSE_CYC,        // power-up pause cycles
    parameter int unsigned REF_LEN   = REF_INTERVAL_CYC, // cycles between refreshes
    parameter bit          USE_CBR   = 1'b1              // init with column-before-row
) (
    input  wire logic               core_clk,  // 40 MHz clock
    input  wire logic               rst,       // synchronous reset, active high
    input  wire logic               reqValid,  // access request
    input  wire access_req_t        req,       // access command
    output logic                    reqReady,  // request taken last cycle
    output logic [DATA_W-1:0]       rdData,    // read data
    output logic                    rdValid,   // read data pulse
    output logic                    ready,     // initialisation done
    output ram_pins_t               pins,      // strobes, address, shift clock
    output logic [DATA_W-1:0]       dqOut,     // data pins driven value
    output logic                    dqOe,      // data pins driven while high
    input  wire logic [DATA_W-1:0]  dqIn       // data pins sampled
);
    typedef enum {PAUSE, INIT, IDLE, PRE, RAS, CAS, HOLD, CBR_CAS, CBR_RAS} st_t;

    st_t              st_r, st_nxt;
    logic [23:0]      cnt_r, cnt_nxt;
    logic [3:0]       initCnt_r, initCnt_nxt;
    logic [ROW_W-1:0] refRow_r, refRow_nxt;
    logic [9:0]       refOwed_r, refOwed_nxt;
    logic             isRef_r, isRef_nxt;
    logic             isCbr_r, isCbr_nxt;
    access_req_t      cur_r, cur_nxt;
    ram_pins_t        pins_nxt;
    logic [DATA_W-1:0] dqOut_nxt, rdData_nxt;
    logic             dqOe_nxt, rdValid_nxt, ready_nxt, reqReady_nxt;
    logic [DATA_W-1:0] dqS1_r, dqS2_r, dqS3_r;
    logic             refTick;

    vram_pace_timer #(.LOAD(REF_LEN)) u_pace (
        .core_clk (core_clk),
        .rst      (rst),
        .restart  (1'b0),
        .tick     (refTick)
    );

    // idle pin state: strobes high, write high, transfer/output-enable high
    function automatic ram_pins_t idlePins();
        ram_pins_t p;
        p = '{rasN: 1'b1, casN: 1'b1, weN: 1'b1, dtOeN: 1'b1, scClk: 1'b0, addr: '0};
        return p;
    endfunction

    always_comb begin
        st_nxt       = st_r;
        cnt_nxt      = (cnt_r == 24'h00_0000) ? cnt_r : cnt_r - 24'h00_0001;
        initCnt_nxt  = initCnt_r;
        refRow_nxt   = refRow_r;
        refOwed_nxt  = refOwed_r + {9'h000, refTick}; // R4 R15
        isRef_nxt    = isRef_r;
        isCbr_nxt    = isCbr_r;
        cur_nxt      = cur_r;
        pins_nxt     = pins;
        dqOut_nxt    = dqOut;
        dqOe_nxt     = dqOe;
        rdData_nxt   = rdData;
        rdValid_nxt  = 1'b0;
        ready_nxt    = ready;
        reqReady_nxt = 1'b0;
        case (st_r)
            PAUSE: begin
                pins_nxt = idlePins(); // R12 R13
                dqOe_nxt = 1'b0;
                if (cnt_r == 24'h00_0000) begin // R1
                    st_nxt      = INIT;
                    initCnt_nxt = 4'h0;
                end
            end
            INIT: begin
                // one shift clock per init cycle with transfer/output-enable high
                pins_nxt.scClk = ~pins.scClk; // R2
                if (initCnt_r == 4'(INIT_CYCLES)) begin
                    pins_nxt.scClk = 1'b0;
                    ready_nxt      = 1'b1;
                    st_nxt         = IDLE;
                end else if (!pins.scClk) begin
                    initCnt_nxt = initCnt_r + 4'h1;
                    isRef_nxt   = 1'b1;
                    isCbr_nxt   = USE_CBR; // R3
                    st_nxt      = PRE;
                    cnt_nxt     = 24'(PRE_CYC - 1);
                end
            end
            IDLE: begin
                pins_nxt = idlePins();
                dqOe_nxt = 1'b0;
                if (refOwed_r != 10'h000) begin // R15
                    isRef_nxt   = 1'b1;
                    isCbr_nxt   = USE_CBR;
                    refOwed_nxt = refOwed_r - 10'h001 + {9'h000, refTick};
                    st_nxt      = PRE;
                    cnt_nxt     = 24'(PRE_CYC - 1);
                end else if (reqValid) begin
                    isRef_nxt    = 1'b0;
                    isCbr_nxt    = 1'b0;
                    cur_nxt      = req;
                    reqReady_nxt = 1'b1;
                    st_nxt       = PRE;
                    cnt_nxt      = 24'(PRE_CYC - 1);
                end
            end
            PRE: begin
                pins_nxt = idlePins();
                if (cnt_r == 24'h00_0000) begin
                    if (isCbr_r) begin
                        pins_nxt.casN = 1'b0; // column strobe first
                        st_nxt        = CBR_CAS;
                        cnt_nxt       = 24'(CSR_CYC - 1);
                    end else begin
                        pins_nxt.addr = isRef_r ? refRow_r : cur_r.row;
                        st_nxt        = RAS;
                        cnt_nxt       = 24'(RCD_CYC);
                    end
                end
            end
            RAS: begin
                pins_nxt.rasN = 1'b0; // R14
                if (cnt_r == 24'h00_0000) begin
                    if (isRef_r) begin
                        refRow_nxt = refRow_r + 9'h001;
                        st_nxt     = HOLD;
                        cnt_nxt    = 24'(RAS_CYC - 1);
                    end else begin
                        pins_nxt.addr  = cur_r.col;
                        pins_nxt.weN   = ~cur_r.write; // R5 R9
                        dqOut_nxt      = cur_r.wdata;  // R8
                        dqOe_nxt       = cur_r.write;
                        pins_nxt.dtOeN = cur_r.write;  // R7
                        st_nxt         = CAS;
                        // one extra cycle so driven data clears the 3-flop sampler
                        cnt_nxt        = 24'(RAS_CYC);
                    end
                end
            end
            CAS: begin
                pins_nxt.casN = 1'b0;
                if (cnt_r == 24'h00_0000) begin
                    // pins sampled one cycle after column strobe fell, delayed by the 3-flop sampler
                    rdData_nxt  = dqS3_r; // R10 R11
                    rdValid_nxt = ~cur_r.write;
                    pins_nxt    = idlePins(); // R9 R14
                    dqOe_nxt    = 1'b0;
                    st_nxt      = ready ? IDLE : INIT;
                end
            end
            CBR_CAS: begin
                if (cnt_r == 24'h00_0000) begin
                    pins_nxt.rasN = 1'b0;
                    st_nxt        = CBR_RAS;
                    cnt_nxt       = 24'(RAS_CYC - 1);
                end
            end
            CBR_RAS, HOLD: begin
                if (cnt_r == 24'h00_0000) begin
                    pins_nxt = idlePins(); // R14
                    st_nxt   = ready ? IDLE : INIT;
                end
            end
            default: st_nxt = PAUSE;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            st_r      <= PAUSE;
            cnt_r     <= 24'(PAUSE_LEN - 1);
            initCnt_r <= 4'h0;
            refRow_r  <= ROW_RESET;
            refOwed_r <= 10'h000;
            isRef_r   <= 1'b0;
            isCbr_r   <= 1'b0;
            cur_r     <= '0;
            pins      <= '{rasN: 1'b1, casN: 1'b1, weN: 1'b1, dtOeN: 1'b1,
                           scClk: 1'b0, addr: '0};
            dqOut     <= 8'h00;
            dqOe      <= 1'b0;
            rdData    <= 8'h00;
            rdValid   <= 1'b0;
            ready     <= 1'b0;
            reqReady  <= 1'b0;
            dqS1_r    <= 8'h00;
            dqS2_r    <= 8'h00;
            dqS3_r    <= 8'h00;
        end else begin
            st_r      <= st_nxt;
            cnt_r     <= cnt_nxt;
            initCnt_r <= initCnt_nxt;
            refRow_r  <= refRow_nxt;
            refOwed_r <= refOwed_nxt;
            isRef_r   <= isRef_nxt;
            isCbr_r   <= isCbr_nxt;
            cur_r     <= cur_nxt;
            pins      <= pins_nxt;
            dqOut     <= dqOut_nxt;
            dqOe      <= dqOe_nxt;
            rdData    <= rdData_nxt;
            rdValid   <= rdValid_nxt;
            ready     <= ready_nxt;
            reqReady  <= reqReady_nxt;
            dqS1_r    <= dqIn;
            dqS2_r    <= dqS1_r;
            dqS3_r    <= dqS2_r;
        end
    end

    AST_PAUSE_STROBES: assert property (@(posedge core_clk) disable iff (rst) // R12
        (st_r == PAUSE) |-> (pins.rasN && pins.dtOeN))
        else $error("strobe low during power-up pause");
    AST_NO_EARLY: assert property (@(posedge core_clk) disable iff (rst) // R1
        $fell(pins.rasN) |-> ready || (st_r != PAUSE))
        else $error("row strobe before pause ended");
    AST_INIT_DT_HIGH: assert property (@(posedge core_clk) disable iff (rst) // R2
        (!ready && st_r != PAUSE) |-> pins.dtOeN)
        else $error("transfer pin low during init");
    AST_CBR_ORDER: assert property (@(posedge core_clk) disable iff (rst) // R3
        (isCbr_r && $fell(pins.rasN)) |-> !pins.casN)
        else $error("column-before-row order broken");
    AST_ROW_FIRST: assert property (@(posedge core_clk) disable iff (rst) // R14
        (!isCbr_r && $fell(pins.rasN)) |-> pins.casN)
        else $error("column strobe low at row strobe fall");
    AST_EARLY_WE: assert property (@(posedge core_clk) disable iff (rst) // R5
        ($fell(pins.casN) && cur_r.write && !isRef_r) |-> !$past(pins.weN))
        else $error("write enable not ahead of column strobe");
    AST_READ_HOLD: assert property (@(posedge core_clk) disable iff (rst) // R9
        ($rose(pins.casN) && !isRef_r && !cur_r.write) |-> pins.weN)
        else $error("write enable dropped in read");
    AST_REF_OWED: assert property (@(posedge core_clk) disable iff (rst) // R4
        refOwed_r < 10'h004)
        else $error("refresh backlog too large");
    AST_DQ_OFF: assert property (@(posedge core_clk) disable iff (rst) // R13
        (!pins.weN == 1'b0) |-> !dqOe)
        else $error("data driven outside a write");
endmodule // vram_host_ctrl
`default_nettype wire

// ### test/vram_dev_model.sv
`timescale 1ns/1ps
`default_nettype none
module vram_dev_model
    import vram_ctrl_pkg::*;
(
    input  wire logic              core_clk, // pace of the floating pattern
    input  wire ram_pins_t         pins,     // strobes from the controller
    input  wire logic [DATA_W-1:0] dqOut,    // controller drive value
    input  wire logic              dqOe,     // controller drives the lines
    output logic [DATA_W-1:0]      dqLine,   // resolved data lines
    output int                     cbrCnt,   // column-before-row cycles seen
    output int                     rasCnt,   // row strobe falls seen
    output int                     scCnt     // shift clocks seen
);
    logic [DATA_W-1:0] mem [bit [17:0]];
    logic [ROW_W-1:0]  rowR;
    logic [17:0]       adr;
    logic              readCyc;
    logic              drv;
    logic [DATA_W-1:0] last;
    initial begin
        cbrCnt = 0;
        rasCnt = 0;
        scCnt = 0;
        readCyc = 1'b0;
        last = 8'h00;
        rowR = '0;
        adr = '0;
    end
    always @(negedge pins.rasN) begin
        rasCnt <= rasCnt + 1;
        if (!pins.casN) cbrCnt <= cbrCnt + 1;
        else rowR <= pins.addr;
    end
    always @(posedge pins.scClk) scCnt <= scCnt + 1;
    always @(negedge pins.casN) begin
        if (!pins.rasN) begin
            adr = {rowR, pins.addr};
            readCyc = pins.weN;
            if (!pins.weN) mem[adr] = dqOut;
        end
    end
    // late write enable turns a read into read-write
    always @(negedge pins.weN) if (readCyc) mem[adr] = dqOut;
    always @(posedge pins.casN) readCyc = 1'b0;
    assign drv = readCyc && !pins.casN && !pins.dtOeN;
    // released lines show a pattern that changes every cycle
    always @(posedge core_clk) if (!dqOe && !drv) last <= ~dqLine;
    assign dqLine = dqOe ? dqOut : (drv ? mem[adr] : last);
endmodule // vram_dev_model
`default_nettype wire

// ### test/vram_init_refresh_write_modes_test.sv
`timescale 1ns/1ps
`default_nettype none
module vram_init_refresh_write_modes_test;
    import vram_ctrl_pkg::*;
    localparam int unsigned PL = 20;
    localparam int unsigned RL = 50;
    logic              core_clk, rst, reqValid, reqReady, rdValid, ready, dqOe;
    access_req_t       req;
    logic [DATA_W-1:0] rdData, dqOut, dqLine;
    ram_pins_t         pins;
    int                cbrCnt, scCnt, bad_count, num_checks, cyc, firstRas;
    int                lastRef, maxGap, refSeen, prevCbr, n;
    logic              badRst, badDt, badRd, prevCas, weFall;
    logic [DATA_W-1:0] refMem [bit [17:0]];
    logic [17:0]       a;
    logic              rdy2, dqOe2;
    ram_pins_t         pins2;
    logic [DATA_W-1:0] dqOut2, dqLine2;
    int                cbr2, sc2, ras2, rasBase;

    vram_host_ctrl #(.PAUSE_LEN(PL), .REF_LEN(RL), .USE_CBR(1'b1)) dut_u (
        .core_clk(core_clk), .rst(rst), .reqValid(reqValid), .req(req),
        .reqReady(reqReady), .rdData(rdData), .rdValid(rdValid), .ready(ready),
        .pins(pins), .dqOut(dqOut), .dqOe(dqOe), .dqIn(dqLine));
    vram_dev_model dev_u (.core_clk(core_clk), .pins(pins), .dqOut(dqOut), .dqOe(dqOe),
        .dqLine(dqLine), .cbrCnt(cbrCnt), .rasCnt(), .scCnt(scCnt));
    // second controller runs the row-only init and refresh mode
    vram_host_ctrl #(.PAUSE_LEN(PL), .REF_LEN(RL), .USE_CBR(1'b0)) row_u (
        .core_clk(core_clk), .rst(rst), .reqValid(1'b0), .req('0),
        .reqReady(), .rdData(), .rdValid(), .ready(rdy2),
        .pins(pins2), .dqOut(dqOut2), .dqOe(dqOe2), .dqIn(dqLine2));
    vram_dev_model dev2_u (.core_clk(core_clk), .pins(pins2), .dqOut(dqOut2), .dqOe(dqOe2),
        .dqLine(dqLine2), .cbrCnt(cbr2), .rasCnt(ras2), .scCnt(sc2));

    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    function automatic logic [DATA_W-1:0] expect_rd(input logic [17:0] ad);
        return refMem[ad];
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic stop_test();
        $display("checks=%0d mismatches=%0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic access(input logic wr, input logic [17:0] ad, input logic [7:0] d);
        int k;
        reqValid = 1'b1;
        req = '{wr, ad[17:9], ad[8:0], d};
        for (k = 0; k < 200 && reqReady !== 1'b1; k++) begin
            @(posedge core_clk);
            #2;
        end
        reqValid = 1'b0;
        check(32'(reqReady === 1'b1), 32'h0000_0001);
        // let the taken pulse end so the next call cannot mistake it for its own
        @(posedge core_clk);
        #2;
        if (!wr) begin
            for (k = 0; k < 40 && rdValid !== 1'b1; k++) begin
                @(posedge core_clk);
                #2;
            end
            check(32'(rdData), 32'(expect_rd(ad)));
        end
    endtask

    // pin watch, sampled mid-cycle where the outputs are settled
    always @(negedge core_clk) begin
        cyc <= rst ? 0 : cyc + 1;
        if (rst && $time > 0 && (pins.rasN !== 1'b1 || pins.dtOeN !== 1'b1)) badRst <= 1'b1;
        if (!rst && ready !== 1'b1 && pins.dtOeN !== 1'b1) badDt <= 1'b1;
        if (!rst && firstRas < 0 && pins.rasN === 1'b0) firstRas <= cyc;
        if (ready === 1'b1 && cbrCnt != prevCbr) begin
            if (lastRef > 0 && cyc - lastRef > maxGap) maxGap <= cyc - lastRef;
            lastRef <= cyc;
            refSeen <= refSeen + 1;
        end
        prevCbr <= cbrCnt;
        if (prevCas === 1'b1 && pins.casN === 1'b0) weFall <= pins.weN;
        if (prevCas === 1'b0 && pins.casN === 1'b1 && weFall === 1'b1 && pins.weN !== 1'b1)
            badRd <= 1'b1;
        prevCas <= pins.casN;
    end

    initial begin
        #(40_000 * 25);
        bad_count++;
        stop_test();
    end

    initial begin
        {badRst, badDt, badRd, prevCas, weFall} = '0;
        rst = 1'b1;
        reqValid = 1'b0;
        req = '0;
        {bad_count, num_checks, cyc, lastRef, maxGap, refSeen, prevCbr} = '0;
        firstRas = -1;
        void'($urandom(32'h0000_b7cc));
        repeat (8) @(posedge core_clk);
        #2;
        rst = 1'b0;
        for (n = 0; n < 3000 && (ready !== 1'b1 || rdy2 !== 1'b1); n++) @(posedge core_clk);
        #2;
        check(32'(ready === 1'b1), 32'h0000_0001);
        check(32'(rdy2 === 1'b1), 32'h0000_0001);
        check(32'(ras2 >= INIT_CYCLES), 32'h0000_0001);
        check(32'(sc2 >= INIT_CYCLES), 32'h0000_0001);
        check(32'(cbr2), 32'h0000_0000);
        check(32'(firstRas >= PL), 32'h0000_0001);
        check(32'(cbrCnt >= INIT_CYCLES), 32'h0000_0001);
        check(32'(scCnt >= INIT_CYCLES), 32'h0000_0001);
        check(32'(badRst | badDt), 32'h0000_0000);
        $display("test init done");
        for (n = 0; n < 16; n++) begin
            a = (n == 0) ? 18'h0_0000 : (n == 1) ? 18'h3_ffff : 18'($urandom);
            refMem[a] = (n < 2) ? {8{n[0]}} : 8'($urandom);
            access(1'b1, a, refMem[a]);
            if (n[1]) access(1'b0, a, 8'h00);
        end
        foreach (refMem[k]) access(1'b0, k, 8'h00);
        check(32'(badRd), 32'h0000_0000);
        $display("test access done");
        n = refSeen;
        rasBase = ras2;
        repeat (REF_ROWS * RL + RL) @(posedge core_clk);
        check(32'(refSeen - n >= REF_ROWS), 32'h0000_0001);
        check(32'(ras2 - rasBase >= REF_ROWS), 32'h0000_0001);
        check(32'(maxGap <= RL + 16), 32'h0000_0001);
        $display("test refresh done");
        stop_test();
    end
endmodule // vram_init_refresh_write_modes_test
`default_nettype wire
